// ---- src_conditioner.sv ----
/*
  Speed reference conditioner: offset removal, volt-to-rpm scaling,
  soft start shaping and reference filter, once per 1 ms control period.
  Assumes all inputs are synchronous to clock; ref_sample is in mV.
*/
`default_nettype none
`include "src_regs.svh"

// How it works
// - The offset-free reference in volts is multiplied by a gain of 0 to 3000 rpm per volt, 150 after reset.
// - The analog reference drives the command only for control mode digits 0, 4, 7, 9 and A.
// - The proportional select input high gives PI control and low gives P-only control.
// - A finished automatic offset measurement is kept and shown later by the manual offset function.
// - Automatic offset measurement runs only with the servo off while the host holds 0 V.
// - Automatic measurement starts only after the mode key is held longer than one second.
// - The manual offset function works like the automatic one but the operator enters the value.
// - With servo on, a one-second enter hold shows the offset, which increment and decrement then change.
// - The form selector picks slope, S curve, first-order or second-order shaping of steps.
// - The acceleration time, 0 to 10000 ms, default 100, is the ramp time from rest to maximum speed.
// - The deceleration time, 0 to 10000 ms, default 100, is the ramp time from maximum speed to rest.
// - With both times at 0 the reference passes with no shaping.
// - A first-order filter of 0 to 10000 ms, default 0 meaning none, smooths the reference.
module src_conditioner
  import src_pkg::*;
#(
  parameter int TICK_CYCLES = `SRC_TICK_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Analog reference sample
  input wire logic signed [15:0] ref_sample,
  // Settings
  input wire logic [11:0] speed_ref_gain_setting,
  input wire logic [3:0] control_mode_select,
  input wire logic prop_control_select_n,
  input wire logic [1:0] soft_start_form_select,
  input wire logic [13:0] accel_time_setting,
  input wire logic [13:0] decel_time_setting,
  input wire logic [13:0] ref_filter_time_setting,
  input wire logic [15:0] motor_max_speed,
  // Panel operator
  input wire logic servo_on,
  input wire logic auto_offset_function,
  input wire logic manual_offset_function,
  input wire logic key_mode,
  input wire logic key_enter,
  input wire logic key_inc,
  input wire logic key_dec,
  // Results
  output logic signed [15:0] speed_cmd,
  output logic speed_cmd_valid,
  output logic pi_mode,
  output logic analog_ref_active,
  output logic signed [15:0] offset_value,
  output logic offset_show,
  output logic auto_offset_done
);

  function automatic logic signed [15:0] sat16(input logic signed [39:0] v);
    if (v > 40'sh00_0000_7fff) begin
      sat16 = 16'sh7fff;
    end else if (v < -40'sh00_0000_7fff) begin
      sat16 = -16'sh7fff;
    end else begin
      sat16 = v[15:0];
    end
  endfunction

  function automatic logic [13:0] clamp_time(input logic [13:0] t);
    clamp_time = (t > `SRC_TIME_MAX) ? `SRC_TIME_MAX : t;
  endfunction

  function automatic logic [15:0] ramp_step(input logic [15:0] vmax,
                                            input logic [13:0] t);
    logic [15:0] q;
    q = (t == 14'h0000) ? vmax : 16'(vmax / {2'h0, t});
    ramp_step = (q == 16'h0000) ? 16'h0001 : q;
  endfunction

  function automatic logic moving_out(input logic signed [15:0] tgt,
                                      input logic signed [15:0] cur);
    moving_out = (tgt >= 0 && cur >= 0 && tgt > cur) ||
                 (tgt <= 0 && cur <= 0 && tgt < cur);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Control period divider and stage enables
  logic [13:0] div_q;
  logic [13:0] div_d;
  logic [5:0] tick_q;
  logic [5:0] tick_d;

  always_comb begin
    div_d = div_q + 14'h0001;
    tick_d = {tick_q[4:0], 1'b0};
    if (div_q == 14'(TICK_CYCLES - 1)) begin
      div_d = 14'h0000;
      tick_d[0] = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      div_q <= '0;
      tick_q <= '0;
    end else begin
      div_q <= div_d;
      tick_q <= tick_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Offset functions
  src_ofs_state_e ofs_st_q;
  src_ofs_state_e ofs_st_d;
  logic [10:0] hold_q;
  logic [10:0] hold_d;
  logic signed [19:0] sum_q;
  logic signed [19:0] sum_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic signed [15:0] ofs_q;
  logic signed [15:0] ofs_d;
  logic inc_prev_q;
  logic dec_prev_q;
  logic done_q;
  logic done_d;

  always_comb begin
    logic held;
    held = (ofs_st_q == SRC_OFS_AUTO_HOLD) ? key_mode : key_enter;
    ofs_st_d = ofs_st_q;
    hold_d = hold_q;
    sum_d = sum_q;
    cnt_d = cnt_q;
    ofs_d = ofs_q;
    done_d = 1'b0;
    if (!held) begin
      hold_d = '0;
    end else if (tick_q[0] && hold_q != 11'h7ff) begin
      hold_d = hold_q + 11'h001;
    end
    case (ofs_st_q)
      SRC_OFS_IDLE: begin
        hold_d = '0;
        if (auto_offset_function && !servo_on) begin
          ofs_st_d = SRC_OFS_AUTO_HOLD;
        end else if (manual_offset_function && servo_on) begin
          ofs_st_d = SRC_OFS_MAN_HOLD;
        end
      end
      SRC_OFS_AUTO_HOLD: begin
        if (!auto_offset_function || servo_on) begin
          ofs_st_d = SRC_OFS_IDLE;
        end else if (hold_q > `SRC_HOLD_MS) begin
          ofs_st_d = SRC_OFS_AUTO_MEAS;
          sum_d = '0;
          cnt_d = '0;
        end
      end
      SRC_OFS_AUTO_MEAS: begin
        if (!auto_offset_function || servo_on) begin
          ofs_st_d = SRC_OFS_IDLE;
        end else if (tick_q[0]) begin
          sum_d = sum_q + 20'(ref_sample);
          cnt_d = cnt_q + 4'h1;
          if (cnt_q == `SRC_OFS_AVG_LAST) begin
            ofs_d = 16'(sum_d >>> `SRC_OFS_AVG_LOG2);
            done_d = 1'b1;
            ofs_st_d = SRC_OFS_IDLE;
          end
        end
      end
      SRC_OFS_MAN_HOLD: begin
        if (!manual_offset_function || !servo_on) begin
          ofs_st_d = SRC_OFS_IDLE;
        end else if (hold_q >= `SRC_HOLD_MS) begin
          ofs_st_d = SRC_OFS_MAN_EDIT;
          hold_d = '0;
        end
      end
      SRC_OFS_MAN_EDIT: begin
        if (key_inc && !inc_prev_q && ofs_q < $signed(`SRC_OFS_LIM)) begin
          ofs_d = ofs_q + $signed(`SRC_OFS_STEP);
        end else if (key_dec && !dec_prev_q &&
                     ofs_q > -$signed(`SRC_OFS_LIM)) begin
          ofs_d = ofs_q - $signed(`SRC_OFS_STEP);
        end
        if (!manual_offset_function || hold_q >= `SRC_HOLD_MS) begin
          ofs_st_d = SRC_OFS_IDLE;
        end
      end
      default: begin
        ofs_st_d = SRC_OFS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      ofs_st_q <= SRC_OFS_IDLE;
      hold_q <= '0;
      sum_q <= '0;
      cnt_q <= '0;
      ofs_q <= '0;
      inc_prev_q <= 1'b0;
      dec_prev_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      ofs_st_q <= ofs_st_d;
      hold_q <= hold_d;
      sum_q <= sum_d;
      cnt_q <= cnt_d;
      ofs_q <= ofs_d;
      inc_prev_q <= key_inc;
      dec_prev_q <= key_dec;
      done_q <= done_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Scaling and soft start ramp
  logic signed [15:0] target_q;
  logic signed [15:0] target_d;
  logic signed [15:0] ramp_q;
  logic signed [15:0] ramp_d;
  logic [13:0] acc_t;
  logic [13:0] dec_t;
  logic bypass;
  logic src_ok;
  logic signed [15:0] lag1_y;
  logic signed [15:0] lag2_y;
  logic signed [15:0] filt_y;
  logic signed [15:0] lag1_x;
  logic signed [15:0] shaped;
  logic [13:0] tau1;
  logic [13:0] tau2;

  assign acc_t = clamp_time(accel_time_setting);
  assign dec_t = clamp_time(decel_time_setting);
  assign bypass = (acc_t == 14'h0000) && (dec_t == 14'h0000);
  assign src_ok = (control_mode_select == `SRC_MODE_SPD) ||
                  (control_mode_select == `SRC_MODE_SPD_POS) ||
                  (control_mode_select == `SRC_MODE_SPD_TRQ) ||
                  (control_mode_select == `SRC_MODE_SPD_ALT) ||
                  (control_mode_select == `SRC_MODE_SPD_ZCL);

  always_comb begin
    logic [11:0] gain;
    logic signed [39:0] diffv;
    logic signed [39:0] rpm;
    logic signed [15:0] lim;
    logic signed [16:0] gap;
    logic [15:0] stp;
    gain = (speed_ref_gain_setting > `SRC_GAIN_MAX) ?
           `SRC_GAIN_MAX : speed_ref_gain_setting;
    diffv = 40'(ref_sample) - 40'(ofs_q);
    rpm = (diffv * $signed({28'h000_0000, gain})) /
          $signed(`SRC_MV_PER_V);
    lim = $signed(motor_max_speed & 16'h7fff);
    target_d = target_q;
    if (tick_q[0]) begin
      target_d = src_ok ? sat16(rpm) : 16'sh0000;
      if (target_d > lim) begin
        target_d = lim;
      end else if (target_d < -lim) begin
        target_d = -lim;
      end
    end
    ramp_d = ramp_q;
    gap = 17'(target_q) - 17'(ramp_q);
    stp = moving_out(target_q, ramp_q) ?
          ramp_step(motor_max_speed, acc_t) :
          ramp_step(motor_max_speed, dec_t);
    if (tick_q[1]) begin
      if (bypass) begin
        ramp_d = target_q;
      end else if (gap > $signed({1'b0, stp})) begin
        ramp_d = ramp_q + $signed(stp);
      end else if (gap < -$signed({1'b0, stp})) begin
        ramp_d = ramp_q - $signed(stp);
      end else begin
        ramp_d = target_q;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      target_q <= '0;
      ramp_q <= '0;
    end else begin
      target_q <= target_d;
      ramp_q <= ramp_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Shaping form selection and delay stages
  always_comb begin
    logic [13:0] base;
    logic signed [15:0] cur_out;
    // Direction is judged on the stage output, not on shaped itself
    cur_out = (soft_start_form_select == `SRC_FORM_LAG2) ? lag2_y : lag1_y;
    base = moving_out(target_q, cur_out) ? acc_t : dec_t;
    tau1 = '0;
    tau2 = '0;
    lag1_x = target_q;
    shaped = target_q;
    if (!bypass) begin
      case (soft_start_form_select)
        `SRC_FORM_SLOPE: begin
          shaped = ramp_q;
        end
        `SRC_FORM_SCURVE: begin
          lag1_x = ramp_q;
          tau1 = base >> 2;
          shaped = lag1_y;
        end
        `SRC_FORM_LAG1: begin
          tau1 = base;
          shaped = lag1_y;
        end
        default: begin
          tau1 = base >> 1;
          tau2 = base >> 1;
          shaped = lag2_y;
        end
      endcase
    end
  end

  src_lag u_lag1 (
    .clock(clock),
    .srst(srst),
    .en(tick_q[2]),
    .x(lag1_x),
    .tau(tau1),
    .y(lag1_y)
  );

  src_lag u_lag2 (
    .clock(clock),
    .srst(srst),
    .en(tick_q[3]),
    .x(lag1_y),
    .tau(tau2),
    .y(lag2_y)
  );

  // Reference filter after shaping
  src_lag u_filt (
    .clock(clock),
    .srst(srst),
    .en(tick_q[4]),
    .x(shaped),
    .tau(clamp_time(ref_filter_time_setting)),
    .y(filt_y)
  );

  //////////////////////////////////////////////////////////////////////////
  // Output registers
  logic signed [15:0] cmd_q;
  logic signed [15:0] cmd_d;
  logic valid_q;
  logic pi_q;
  logic active_q;
  logic show_q;

  always_comb begin
    cmd_d = tick_q[5] ? filt_y : cmd_q;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      cmd_q <= '0;
      valid_q <= 1'b0;
      pi_q <= 1'b0;
      active_q <= 1'b0;
      show_q <= 1'b0;
    end else begin
      cmd_q <= cmd_d;
      valid_q <= tick_q[5];
      pi_q <= prop_control_select_n;
      active_q <= src_ok;
      show_q <= (ofs_st_d == SRC_OFS_MAN_EDIT);
    end
  end

  assign speed_cmd = cmd_q;
  assign speed_cmd_valid = valid_q;
  assign pi_mode = pi_q;
  assign analog_ref_active = active_q;
  assign offset_value = ofs_q;
  assign offset_show = show_q;
  assign auto_offset_done = done_q;

endmodule

`default_nettype wire

// ---- src_conditioner_sva.sv ----
/*
  Port checker of the speed reference conditioner.
  Assumes it is bound into src_conditioner with the same tick count.
*/
`default_nettype none

module src_cond_sva
  import src_pkg::*;
#(
  parameter int TICK_CYCLES = 20
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Watched inputs
  input wire logic [3:0] control_mode_select,
  input wire logic prop_control_select_n,
  input wire logic servo_on,
  input wire logic auto_offset_function,
  input wire logic manual_offset_function,
  input wire logic key_enter,
  // Watched outputs
  input wire logic signed [15:0] speed_cmd,
  input wire logic speed_cmd_valid,
  input wire logic pi_mode,
  input wire logic analog_ref_active,
  input wire logic signed [15:0] offset_value,
  input wire logic offset_show,
  input wire logic auto_offset_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] gap_q, gap_d;
  logic seen_q, seen_d;
  logic spd_src;

  always_comb begin
    gap_d = speed_cmd_valid ? 16'h0000 : gap_q + 16'h0001;
    seen_d = seen_q | speed_cmd_valid;
    spd_src = control_mode_select inside {4'h0, 4'h4, 4'h7, 4'h9, 4'ha};
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      gap_q <= 16'h0000;
      seen_q <= 1'b0;
    end else begin
      gap_q <= gap_d;
      seen_q <= seen_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  default clocking @(posedge clock); endclocking
  default disable iff (srst);

  property p_period;
    speed_cmd_valid && seen_q |-> gap_q == 16'(TICK_CYCLES - 1);
  endproperty
  a_period: assert property (p_period) else $error("cmd period");

  property p_hold;
    $changed(speed_cmd) |-> speed_cmd_valid;
  endproperty
  a_hold: assert property (p_hold) else $error("cmd moved");

  property p_pi;
    !$past(srst) |-> pi_mode == $past(prop_control_select_n);
  endproperty
  a_pi: assert property (p_pi) else $error("pi mode");

  property p_src;
    !$past(srst) |-> analog_ref_active == $past(spd_src);
  endproperty
  a_src: assert property (p_src) else $error("analog source");

  property p_auto;
    auto_offset_done |-> !$past(servo_on) && $past(auto_offset_function)
      ##1 !auto_offset_done;
  endproperty
  a_auto: assert property (p_auto) else $error("auto offset");

  property p_ofs_src;
    $changed(offset_value) |-> auto_offset_done || offset_show;
  endproperty
  a_ofs_src: assert property (p_ofs_src) else $error("offset src");

  property p_step;
    offset_show && $past(offset_show) && $changed(offset_value) |->
      (offset_value - $past(offset_value)) inside {16'h0001, 16'hffff};
  endproperty
  a_step: assert property (p_step) else $error("offset step");

  property p_lim;
    offset_show |-> offset_value <= 16'sh03e8 && offset_value >= -16'sh03e8;
  endproperty
  a_lim: assert property (p_lim) else $error("offset limit");

  property p_show;
    $rose(offset_show) |-> $past(manual_offset_function) && $past(servo_on)
      && $past(key_enter);
  endproperty
  a_show: assert property (p_show) else $error("offset show");

  c_done: cover property (auto_offset_done);
  c_show: cover property ($rose(offset_show));
  c_step: cover property (offset_show && $changed(offset_value));
endmodule

bind src_conditioner src_cond_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (
  .clock(clock), .srst(srst), .control_mode_select(control_mode_select),
  .prop_control_select_n(prop_control_select_n), .servo_on(servo_on),
  .auto_offset_function(auto_offset_function),
  .manual_offset_function(manual_offset_function), .key_enter(key_enter),
  .speed_cmd(speed_cmd), .speed_cmd_valid(speed_cmd_valid),
  .pi_mode(pi_mode), .analog_ref_active(analog_ref_active),
  .offset_value(offset_value), .offset_show(offset_show),
  .auto_offset_done(auto_offset_done));

`default_nettype wire

// ---- src_host_model.sv ----
/*
  Host controller model driving the digitised speed reference.
  Assumes the bench selects a level or a zero request each cycle.
*/
`default_nettype none

module src_host_model
  import src_pkg::*;
#(
  parameter logic signed [15:0] DRIFT_MV = 16'sh0007
) (
  // Clock
  input wire logic clock,
  // Requests from the bench
  input wire logic hold_zero,
  input wire logic signed [15:0] level_mv,
  // Reference towards the drive
  output logic signed [15:0] ref_sample
);
  timeunit 1ns;
  timeprecision 1ns;
  initial ref_sample = 16'sh0000;

  // A zero request still carries the line's small drift
  always @(posedge clock) begin
    ref_sample <= hold_zero ? DRIFT_MV : level_mv;
  end
endmodule

`default_nettype wire

// ---- src_lag.sv ----
/*
  First-order delay stage updated once per control period.
  Assumes en is a one-cycle pulse and tau is in control periods.
*/
`default_nettype none
`include "src_regs.svh"

module src_lag
  import src_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Stage input
  input wire logic en,
  input wire logic signed [15:0] x,
  input wire logic [13:0] tau,
  // Stage output
  output logic signed [15:0] y
);

  logic signed [31:0] acc_q;
  logic signed [31:0] acc_d;
  logic signed [15:0] y_q;
  logic signed [15:0] y_d;

  //////////////////////////////////////////////////////////////////////////
  // y += (x - y) / (tau + 1); zero tau passes x straight through
  always_comb begin
    logic signed [33:0] diff;
    logic signed [33:0] den;
    logic signed [33:0] stepv;
    diff = '0;
    den = '0;
    stepv = '0;
    acc_d = acc_q;
    if (en) begin
      if (tau == 14'h0000) begin
        acc_d = {x, 16'h0000};
      end else begin
        diff = 34'($signed({x, 16'h0000})) - 34'(acc_q);
        den = $signed({20'h0_0000, tau}) + 34'sh0_0000_0001;
        stepv = diff / den;
        acc_d = acc_q + 32'(stepv);
      end
    end
    y_d = acc_d[31:`SRC_LAG_FRAC];
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      acc_q <= '0;
      y_q <= '0;
    end else begin
      acc_q <= acc_d;
      y_q <= y_d;
    end
  end

  assign y = y_q;

endmodule

`default_nettype wire

// ---- src_pkg.sv ----
/*
  Types of the speed reference conditioner.
  Assumes src_regs.svh is on the include path.
*/
`default_nettype none

package src_pkg;
  `include "src_regs.svh"

  // Offset function states, Gray along idle-hold-measure and idle-hold-edit
  typedef enum logic [2:0] {
    SRC_OFS_IDLE = 3'h0,
    SRC_OFS_AUTO_HOLD = 3'h1,
    SRC_OFS_AUTO_MEAS = 3'h3,
    SRC_OFS_MAN_HOLD = 3'h4,
    SRC_OFS_MAN_EDIT = 3'h6
  } src_ofs_state_e;

  typedef logic signed [15:0] src_speed_t;
endpackage

`default_nettype wire

// ---- src_regs.svh ----
/*
  Constants of the speed reference conditioner: clock rate, control
  period, setting limits, offset hold times and fixed-point layout.
  Assumes it is included by the package and modules of this block only.
*/
`ifndef SRC_REGS_SVH
`define SRC_REGS_SVH

// Clock and control period
`define SRC_CLK_KHZ 32'h0000_2710
`define SRC_CTRL_PERIOD_MS 32'h0000_0001
`define SRC_TICK_CYC (`SRC_CLK_KHZ * `SRC_CTRL_PERIOD_MS)

// Setting limits and defaults
`define SRC_GAIN_MAX 12'h0bb8
`define SRC_GAIN_DEF 12'h0096
`define SRC_TIME_MAX 14'h2710
`define SRC_ACCEL_DEF 14'h0064
`define SRC_DECEL_DEF 14'h0064
`define SRC_FILT_DEF 14'h0000

// Reference scaling: sample is in mV, gain in rpm per volt
`define SRC_MV_PER_V 40'h00_0000_03e8

// Control mode digits that take the analog reference
`define SRC_MODE_SPD 4'h0
`define SRC_MODE_SPD_POS 4'h4
`define SRC_MODE_SPD_TRQ 4'h7
`define SRC_MODE_SPD_ALT 4'h9
`define SRC_MODE_SPD_ZCL 4'ha

// Soft start forms
`define SRC_FORM_SLOPE 2'h0
`define SRC_FORM_SCURVE 2'h1
`define SRC_FORM_LAG1 2'h2
`define SRC_FORM_LAG2 2'h3

// Offset handling
`define SRC_HOLD_MS 11'h3e8
`define SRC_OFS_LIM 16'h03e8
`define SRC_OFS_AVG_LOG2 4
`define SRC_OFS_AVG_LAST 4'hf
`define SRC_OFS_STEP 16'h0001

// Fixed-point fraction bits of the delay filters
`define SRC_LAG_FRAC 16

`endif

// ---- testbench.sv ----
/*
  Self-checking bench of the speed reference conditioner.
  Assumes the host model and the bound checker are compiled first.
*/
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
  err_total++; $display("unexpected %0t got %0d exp %0d", $time, g, e); \
  end end

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TICK = 20;
  localparam int LIMIT = 95000;
  typedef struct packed {
    logic signed [15:0] lvl;
    logic [11:0] gain;
    logic signed [15:0] cmd;
  } src_row_s;
  src_row_s rows[9] = '{'{16'sh03e8, 12'h0096, 16'sh0096},
    '{16'sh07d0, 12'h0bb8, 16'sh1770}, '{-16'sh05dc, 12'h0096, -16'sh00e1},
    '{16'sh014d, 12'h0007, 16'sh0002}, '{-16'sh014d, 12'h0007, -16'sh0002},
    '{16'sh0fa0, 12'h0bb8, 16'sh1770}, '{-16'sh0fa0, 12'h0bb8, -16'sh1770},
    '{16'sh03e8, 12'h0fff, 16'sh0bb8}, '{16'sh03e8, 12'h0000, 16'sh0000}};
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic hold_zero = 1'b0;
  logic signed [15:0] level_mv = 16'sh0000;
  logic signed [15:0] ref_sample, speed_cmd, offset_value;
  logic [11:0] gain = 12'h0096;
  logic [3:0] mode = 4'h0;
  logic psel_n = 1'b0;
  logic [1:0] form = 2'h0;
  logic [13:0] acc_t = 14'h0000, dec_t = 14'h0000, filt_t = 14'h0000;
  logic servo = 1'b0, auto_fn = 1'b0, man_fn = 1'b0;
  logic k_mode = 1'b0, k_ent = 1'b0, k_inc = 1'b0, k_dec = 1'b0;
  logic speed_cmd_valid, pi_mode, analog_ref_active;
  logic offset_show, auto_offset_done;
  int err_total = 0, check_count = 0, cyc = 0, dones = 0;
  logic signed [15:0] tr[0:23];

  always #50 clock = ~clock;

  src_host_model u_host (.clock(clock), .hold_zero(hold_zero),
    .level_mv(level_mv), .ref_sample(ref_sample));

  src_conditioner #(.TICK_CYCLES(TICK)) u_dut (.clock(clock), .srst(srst),
    .ref_sample(ref_sample), .speed_ref_gain_setting(gain),
    .control_mode_select(mode), .prop_control_select_n(psel_n),
    .soft_start_form_select(form), .accel_time_setting(acc_t),
    .decel_time_setting(dec_t), .ref_filter_time_setting(filt_t),
    .motor_max_speed(16'h1770), .servo_on(servo),
    .auto_offset_function(auto_fn), .manual_offset_function(man_fn),
    .key_mode(k_mode), .key_enter(k_ent), .key_inc(k_inc), .key_dec(k_dec),
    .speed_cmd(speed_cmd), .speed_cmd_valid(speed_cmd_valid),
    .pi_mode(pi_mode), .analog_ref_active(analog_ref_active),
    .offset_value(offset_value), .offset_show(offset_show),
    .auto_offset_done(auto_offset_done));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cyc++;
    if (auto_offset_done === 1'b1) dones++;
    if (cyc == LIMIT) begin
      err_total++;
      $display("unexpected %0t run too long", $time);
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////
  task automatic wait_valid();
    int n;
    n = 0;
    @(negedge clock);
    while (speed_cmd_valid !== 1'b1 && n < 3 * TICK) begin
      @(negedge clock);
      n++;
    end
    `CHK(n < 3 * TICK, 1'b1)
  endtask

  task automatic settle();
    wait_valid();
    wait_valid();
  endtask

  task automatic capture(input int n);
    for (int k = 0; k < n; k++) begin
      wait_valid();
      tr[k] = speed_cmd;
    end
  endtask

  task automatic check_ramp(input int n, input int step,
      input logic signed [15:0] a, input logic signed [15:0] b,
      input int mid);
    int m;
    m = 0;
    capture(n);
    for (int k = 0; k < n; k++) begin
      if (k > 0 && tr[k] != tr[k-1]) `CHK(tr[k] - tr[k-1], 16'(step))
      if ((tr[k] > a && tr[k] < b) || (tr[k] < a && tr[k] > b)) m++;
    end
    `CHK(m, mid)
    `CHK(tr[n-1], b)
  endtask

  task automatic wait_flag(input bit show, input int lim, output int n);
    n = 0;
    while ((show ? offset_show : auto_offset_done) !== 1'b1 && n < lim) begin
      @(negedge clock);
      n++;
    end
  endtask

  task automatic tap(input logic up);
    @(posedge clock);
    k_inc <= up;
    k_dec <= ~up;
    @(posedge clock);
    k_inc <= 1'b0;
    k_dec <= 1'b0;
    repeat (2) @(posedge clock);
    @(negedge clock);
  endtask

  ////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    int j;
    logic signed [15:0] fz;
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      @(posedge clock);
      level_mv <= rows[i].lvl;
      gain <= rows[i].gain;
      psel_n <= i[0];
      settle();
      `CHK(speed_cmd, rows[i].cmd)
      `CHK(pi_mode, i[0])
    end
    $display("test rows ended");
    @(posedge clock);
    gain <= 12'h0096;
    level_mv <= 16'sh03e8;
    for (int m = 0; m < 16; m++) begin
      @(posedge clock);
      mode <= 4'(m);
      settle();
      `CHK(analog_ref_active, 1'(m inside {0, 4, 7, 9, 10}))
      `CHK(speed_cmd, m inside {0, 4, 7, 9, 10} ? 16'sh0096 : 16'sh0000)
    end
    $display("test modes ended");
    @(posedge clock);
    mode <= 4'h0;
    gain <= 12'h0bb8;
    level_mv <= 16'sh0000;
    settle();
    @(posedge clock);
    acc_t <= 14'h000a;
    dec_t <= 14'h0014;
    level_mv <= 16'sh07d0;
    check_ramp(14, 600, 16'sh0000, 16'sh1770, 9);
    @(posedge clock);
    level_mv <= 16'sh0000;
    check_ramp(24, -300, 16'sh1770, 16'sh0000, 19);
    $display("test ramps ended");
    for (int f = 1; f < 4; f++) begin
      @(posedge clock);
      form <= 2'h0;
      acc_t <= 14'h0000;
      dec_t <= 14'h0000;
      level_mv <= 16'sh0000;
      settle();
      @(posedge clock);
      form <= 2'(f);
      acc_t <= 14'h000a;
      level_mv <= 16'sh07d0;
      capture(14);
      fz = 16'sh0000;
      for (int k = 13; k >= 0; k--) if (tr[k] != 16'sh0000) fz = tr[k];
      `CHK(fz != 16'sh0258 && fz != 16'sh0000, 1'b1)
    end
    @(posedge clock);
    form <= 2'h0;
    acc_t <= 14'h0000;
    level_mv <= 16'sh0000;
    settle();
    @(posedge clock);
    filt_t <= 14'h000a;
    level_mv <= 16'sh07d0;
    capture(4);
    j = 0;
    while (tr[j] == 16'sh0000 && j < 2) j++;
    `CHK(tr[j], 16'sh0221)
    `CHK(tr[j+1], 16'sh0411)
    @(posedge clock);
    filt_t <= 14'h0000;
    $display("test shaping ended");
    hold_zero <= 1'b1;
    servo <= 1'b1;
    auto_fn <= 1'b1;
    k_mode <= 1'b1;
    repeat (1030 * TICK) @(posedge clock);
    `CHK(dones, 0)
    servo <= 1'b0;
    k_mode <= 1'b0;
    @(posedge clock);
    k_mode <= 1'b1;
    @(negedge clock);
    wait_flag(1'b0, 1025 * TICK, n);
    `CHK(n >= 1000 * TICK && n < 1025 * TICK, 1'b1)
    `CHK(offset_value, 16'sh0007)
    @(posedge clock);
    k_mode <= 1'b0;
    auto_fn <= 1'b0;
    hold_zero <= 1'b0;
    $display("test auto offset ended");
    // Host closes its own position loop, so it sets the offset by hand
    man_fn <= 1'b1;
    servo <= 1'b1;
    k_ent <= 1'b1;
    wait_flag(1'b1, 1010 * TICK, n);
    `CHK(offset_show, 1'b1)
    `CHK(offset_value, 16'sh0007)
    @(posedge clock);
    k_ent <= 1'b0;
    repeat (3) tap(1'b1);
    tap(1'b0);
    `CHK(offset_value, 16'sh0009)
    repeat (1000) tap(1'b1);
    `CHK(offset_value, 16'sh03e8)
    @(posedge clock);
    man_fn <= 1'b0;
    gain <= 12'h03e8;
    level_mv <= 16'sh05dc;
    repeat (3) @(negedge clock);
    `CHK(offset_show, 1'b0)
    settle();
    `CHK(speed_cmd, 16'sh01f4)
    $display("test manual offset ended");
    @(posedge clock);
    srst <= 1'b1;
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    @(negedge clock);
    `CHK(speed_cmd, 16'sh0000)
    `CHK(offset_value, 16'sh0000)
    $display("test reset ended");
    stop_test();
  end
endmodule

`default_nettype wire
